//--- src/fcm_pkg.sv
// Shared constants, types and opcode decode for the float convert / multiply-accumulate datapath
// Functional notes
// RQ1 - Memory int-to-float result lands after delay slot
// RQ2 - Delay slot never touches conversion destination
// RQ3 - Decode register int-to-float opcode and fields
// RQ4 - Source register taken as signed 32-bit
// RQ5 - Memory int-to-float converts fetched signed word
// RQ6 - Conversions leave every status flag untouched
// RQ7 - Product to chosen register, reg3 += reg2
// RQ8 - Decode multiply with parallel add opcode
// RQ9 - Product destination must not be register three
// RQ10 - Either op sets latched underflow or overflow
// RQ11 - Multiply and add both take two cycles
// RQ12 - Delay slot avoids both pair destinations
// RQ13 - Accumulate, multiply and memory load together
// RQ14 - Decode multiply-accumulate with load opcode
// RQ15 - Load destination differs from reg3 and product
// RQ16 - Add or multiply sets latched range flags
// RQ17 - Loaded word sets negative and zero flags
// RQ18 - Accumulate two cycles, load one cycle
// RQ19 - Delay slot avoids reg3 and product destination
// RQ20 - Register fields pick one of eight registers
// RQ21 - Wide integers round per current rounding mode
package fcm_pkg;
	localparam int unsigned          NUM_REGS       = 8;
	localparam logic [31:0]          REG_RESET      = 32'h0000_0000;
	localparam logic                 FLAG_RESET     = 1'b0;
	localparam logic [2:0]           REG_ACC        = 3'h3;
	localparam logic [2:0]           REG_ADDEND     = 3'h2;
	localparam logic [15:0]          OP_CVT_REG_LSW = 16'he689;
	localparam logic [9:0]           OP_CVT_REG_MSW = 10'h000;
	localparam logic [15:0]          OP_CVT_MEM_LSW = 16'he288;
	localparam logic [4:0]           OP_CVT_MEM_MSW = 5'h00;
	localparam logic [13:0]          OP_MPAR_LSW    = 14'h39d0;
	localparam logic [11:0]          OP_MLD_LSW     = 12'he33;
	localparam logic signed [10:0]   EXP_MAX        = 11'sh0ff;
	localparam logic signed [10:0]   EXP_INT_TOP    = 11'sh09e;
	localparam logic signed [10:0]   EXP_MUL_BIAS   = 11'sh07e;

	typedef enum logic [2:0] {
		FCM_NONE    = 3'b000,
		FCM_CVT_REG = 3'b001,
		FCM_CVT_MEM = 3'b010,
		FCM_MAC_PAR = 3'b011,
		FCM_MAC_LD  = 3'b100
	} fcm_kind_t;

	typedef struct packed {
		fcm_kind_t  kind;
		logic [2:0] a;
		logic [2:0] b;
		logic [2:0] d;
		logic [2:0] e;
		logic [2:0] f;
	} fcm_dec_t;

	// Splits an instruction word pair into its kind and three-bit register fields
	function automatic fcm_dec_t fcm_decode(input logic [15:0] lsw, input logic [15:0] msw);
		fcm_dec_t r;
		r.kind = FCM_NONE;
		r.a    = msw[2:0];
		r.b    = msw[5:3];
		r.d    = msw[11:9];
		r.e    = msw[14:12];
		r.f    = {lsw[1:0], msw[15]};
		if (lsw == OP_CVT_REG_LSW && msw[15:6] == OP_CVT_REG_MSW) begin  // see RQ3
			r.kind = FCM_CVT_REG;
		end else if (lsw == OP_CVT_MEM_LSW && msw[15:11] == OP_CVT_MEM_MSW) begin
			r.kind = FCM_CVT_MEM;
			r.a    = msw[10:8];
		end else if (lsw[15:2] == OP_MPAR_LSW) begin  // see RQ8
			r.kind = FCM_MAC_PAR;
		end else if (lsw[15:4] == OP_MLD_LSW) begin  // see RQ14
			r.kind = FCM_MAC_LD;
			r.f    = lsw[3:1];
			r.e    = {lsw[0], msw[15:14]};
			r.d    = msw[13:11];
			r.a    = msw[10:8];
		end
		return r;
	endfunction : fcm_decode
endpackage : fcm_pkg

//--- src/fcm_if.sv
// Issue link between the host core and the float datapath
`timescale 1ns/1ns
`default_nettype none
interface fcm_if;
	logic        issue_valid;
	logic [15:0] issue_lsw;
	logic [15:0] issue_msw;
	logic [31:0] issue_mem;
	logic        round_zero;

	modport host (
		output issue_valid,
		output issue_lsw,
		output issue_msw,
		output issue_mem,
		output round_zero
	);

	modport device (
		input issue_valid,
		input issue_lsw,
		input issue_msw,
		input issue_mem,
		input round_zero
	);
endinterface : fcm_if
`default_nettype wire

//--- src/fcm_host.sv
// Host end: issues instructions and holds back delay-slot conflicts
`timescale 1ns/1ns
`default_nettype none
module fcm_host (
	input  wire logic  i_clk,
	input  wire logic  i_rst_b,
	fcm_if.host        link,
	input  wire logic  i_valid,
	input  wire logic [15:0] i_lsw,
	input  wire logic [15:0] i_msw,
	input  wire logic [31:0] i_mem,
	input  wire logic  i_round_zero,
	output logic       o_ready,
	output logic       o_illegal
);
	function automatic logic [7:0] one_hot(input logic [2:0] x);
		return 8'h01 << x;
	endfunction : one_hot

	// Every register the instruction reads or writes
	function automatic logic [7:0] use_mask(input fcm_pkg::fcm_dec_t d);
		logic [7:0] mac;
		mac = one_hot(d.d) | one_hot(d.e) | one_hot(d.f) | one_hot(fcm_pkg::REG_ACC)
			| one_hot(fcm_pkg::REG_ADDEND);
		case (d.kind)
			fcm_pkg::FCM_CVT_REG: return one_hot(d.a) | one_hot(d.b);
			fcm_pkg::FCM_CVT_MEM: return one_hot(d.a);
			fcm_pkg::FCM_MAC_PAR: return mac;
			fcm_pkg::FCM_MAC_LD:  return mac | one_hot(d.a);
			default:              return 8'h00;
		endcase
	endfunction : use_mask

	// Destinations that are still in flight during the next slot
	function automatic logic [7:0] pend_mask(input fcm_pkg::fcm_dec_t d);
		case (d.kind)
			fcm_pkg::FCM_CVT_REG,
			fcm_pkg::FCM_CVT_MEM: return one_hot(d.a);  // see RQ2
			fcm_pkg::FCM_MAC_PAR,
			fcm_pkg::FCM_MAC_LD:  return one_hot(d.d) | one_hot(fcm_pkg::REG_ACC);  // see RQ12 RQ19
			default:              return 8'h00;
		endcase
	endfunction : pend_mask

	fcm_pkg::fcm_dec_t new_dec;
	fcm_pkg::fcm_dec_t cur_dec;
	wire logic         hazard;
	wire logic         bad_form;
	wire logic         accept;

	assign new_dec  = fcm_pkg::fcm_decode(i_lsw, i_msw);
	assign cur_dec  = fcm_pkg::fcm_decode(link.issue_lsw, link.issue_msw);
	assign hazard   = link.issue_valid && (|(use_mask(new_dec) & pend_mask(cur_dec)));
	assign bad_form = (new_dec.kind == fcm_pkg::FCM_MAC_PAR && new_dec.d == fcm_pkg::REG_ACC)  // see RQ9
		|| (new_dec.kind == fcm_pkg::FCM_MAC_LD
		&& (new_dec.a == fcm_pkg::REG_ACC || new_dec.a == new_dec.d));  // see RQ15
	assign o_ready  = !hazard;
	assign accept   = i_valid && !hazard;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			link.issue_valid <= 1'b0;
			o_illegal        <= 1'b0;
		end else begin
			link.issue_valid <= accept && !bad_form;
			o_illegal        <= accept && bad_form;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			link.issue_lsw  <= 16'h0000;
			link.issue_msw  <= 16'h0000;
			link.issue_mem  <= 32'h0000_0000;
			link.round_zero <= 1'b0;
		end else if (accept) begin
			link.issue_lsw  <= i_lsw;
			link.issue_msw  <= i_msw;
			link.issue_mem  <= i_mem;
			link.round_zero <= i_round_zero;
		end
	end
endmodule : fcm_host
`default_nettype wire

//--- src/fcm_device.sv
// Device end: decode, two-stage float arithmetic, register file and status flags
`timescale 1ns/1ns
`default_nettype none
module fcm_device (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	fcm_if.device            link,
	input  wire logic [2:0]  i_rd_sel,
	output logic      [31:0] o_rd_data,
	output logic             o_test_result_flag,
	output logic             o_integer_zero_flag,
	output logic             o_integer_negative_flag,
	output logic             o_float_zero_flag,
	output logic             o_float_negative_flag,
	output logic             o_latched_underflow_flag,
	output logic             o_latched_overflow_flag
);
	// Result word layout: {underflow, overflow, value[31:0]}
	function automatic logic [33:0] round_pack(
		input logic              s,
		input logic signed [10:0] e,
		input logic [26:0]       m,
		input logic              rz
	);
		logic [24:0]        r;
		logic signed [10:0] ee;
		logic               up;
		// Nearest-even unless truncation is selected
		up = !rz && m[2] && (m[3] | m[1] | m[0]);  // see RQ21
		r  = {1'b0, m[26:3]} + {24'h000000, up};
		ee = r[24] ? e + 11'sh001 : e;
		if (r[24]) begin
			r = r >> 1;
		end
		if (ee >= fcm_pkg::EXP_MAX) begin
			return {2'b01, s, rz ? 31'h7f7fffff : 31'h7f800000};
		end
		// Results below the normal range flush to zero
		if (ee <= 11'sh000) begin
			return {2'b10, s, 31'h00000000};
		end
		return {2'b00, s, ee[7:0], r[22:0]};
	endfunction : round_pack

	// Bit 49 of v weighs 2^(e - bias); shifts the leading one up before rounding
	function automatic logic [33:0] normalize(
		input logic              s,
		input logic signed [10:0] e,
		input logic [49:0]       v,
		input logic              rz
	);
		logic [5:0]  lz;
		logic [49:0] n;
		lz = 6'h00;
		for (int i = 0; i < 50; i++) begin
			if (v[i]) begin
				lz = 6'(49 - i);
			end
		end
		n = v << lz;
		if (v == 50'h0) begin
			return {2'b00, 32'h0000_0000};
		end
		return round_pack(s, e - $signed({5'h00, lz}), {n[49:24], |n[23:0]}, rz);
	endfunction : normalize

	function automatic logic [33:0] int_to_float(input logic [31:0] x, input logic rz);
		logic [31:0] mag;
		// Two's complement magnitude; the most negative word stays 2^31
		mag = x[31] ? 32'h0000_0000 - x : x;  // see RQ4
		return normalize(x[31], fcm_pkg::EXP_INT_TOP, {mag, 18'h00000}, rz);
	endfunction : int_to_float

	function automatic logic [33:0] float_mul(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic        rz
	);
		logic               s;
		logic [47:0]        p;
		logic signed [10:0] e;
		s = a[31] ^ b[31];
		// Zero and subnormal operands give a signed zero
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
			return {2'b00, s, 31'h00000000};
		end
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]}) - fcm_pkg::EXP_MUL_BIAS;
		return normalize(s, e, {p, 2'b00}, rz);
	endfunction : float_mul

	function automatic logic [33:0] float_add(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic        rz
	);
		logic [31:0]        x;
		logic [31:0]        y;
		logic [7:0]         d;
		logic [49:0]        vx;
		logic [49:0]        vy;
		logic [49:0]        vs;
		logic [49:0]        sum;
		logic               lost;
		logic signed [10:0] e;
		if (a[30:0] >= b[30:0]) begin
			x = a;
			y = b;
		end else begin
			x = b;
			y = a;
		end
		vx = (x[30:23] == 8'h00) ? 50'h0 : {2'b01, x[22:0], 25'h0000000};
		vy = (y[30:23] == 8'h00) ? 50'h0 : {2'b01, y[22:0], 25'h0000000};
		d  = x[30:23] - y[30:23];
		vs = (d > 8'h31) ? 50'h0 : vy >> d;
		// Bits shifted out of the smaller operand fold into a sticky bit
		lost = (vs << d) != vy;
		vs   = vs | {49'h0, lost};
		sum  = (x[31] == y[31]) ? vx + vs : vx - vs;
		e    = $signed({3'h0, x[30:23]}) + 11'sh001;
		return normalize(x[31], e, sum, rz);
	endfunction : float_add

	logic [31:0] regs [fcm_pkg::NUM_REGS];

	// Issue-stage decode
	fcm_pkg::fcm_dec_t dec;
	wire logic         is_cvt;
	wire logic         is_mac;
	wire logic         is_load;
	wire logic [31:0]  load_word;
	wire logic [31:0]  src_x;

	assign dec       = fcm_pkg::fcm_decode(link.issue_lsw, link.issue_msw);
	assign is_cvt    = link.issue_valid && (dec.kind == fcm_pkg::FCM_CVT_REG
		|| dec.kind == fcm_pkg::FCM_CVT_MEM);
	assign is_mac    = link.issue_valid && (dec.kind == fcm_pkg::FCM_MAC_PAR
		|| dec.kind == fcm_pkg::FCM_MAC_LD);
	assign is_load   = link.issue_valid && dec.kind == fcm_pkg::FCM_MAC_LD;
	assign load_word = link.issue_mem;
	// Register source, memory word, or first multiplier source; fields are 3-bit indexes
	assign src_x     = (dec.kind == fcm_pkg::FCM_CVT_MEM) ? link.issue_mem :  // see RQ5
		(dec.kind == fcm_pkg::FCM_CVT_REG) ? regs[dec.b] : regs[dec.e];  // see RQ20

	// Execute stage: operands captured at issue, results written one edge later
	logic        p_cvt;
	logic        p_mac;
	logic [2:0]  p_dst;
	logic [31:0] p_x;
	logic [31:0] p_y;
	logic [31:0] p_acc;
	logic [31:0] p_add;
	logic        p_rz;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			p_cvt <= 1'b0;
			p_mac <= 1'b0;
		end else begin
			p_cvt <= is_cvt;  // see RQ1
			p_mac <= is_mac;  // see RQ11 RQ18
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			p_dst <= 3'h0;
			p_x   <= fcm_pkg::REG_RESET;
			p_y   <= fcm_pkg::REG_RESET;
			p_acc <= fcm_pkg::REG_RESET;
			p_add <= fcm_pkg::REG_RESET;
			p_rz  <= 1'b0;
		end else if (is_cvt || is_mac) begin
			p_dst <= is_cvt ? dec.a : dec.d;
			p_x   <= src_x;
			p_y   <= regs[dec.f];
			p_acc <= regs[fcm_pkg::REG_ACC];
			p_add <= regs[fcm_pkg::REG_ADDEND];
			p_rz  <= link.round_zero;
		end
	end

	wire logic [33:0] cvt_res;
	wire logic [33:0] mul_res;
	wire logic [33:0] add_res;

	assign cvt_res = int_to_float(p_x, p_rz);
	assign mul_res = float_mul(p_x, p_y, p_rz);
	assign add_res = float_add(p_acc, p_add, p_rz);

	// Writeback; the one-cycle load is newest, so it is applied last
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < fcm_pkg::NUM_REGS; i++) begin
				regs[i] <= fcm_pkg::REG_RESET;
			end
		end else begin
			if (p_cvt) begin
				regs[p_dst] <= cvt_res[31:0];
			end
			if (p_mac) begin
				regs[p_dst]            <= mul_res[31:0];  // see RQ7
				regs[fcm_pkg::REG_ACC] <= add_res[31:0];  // see RQ7
			end
			if (is_load) begin
				regs[dec.a] <= load_word;  // see RQ13 RQ18
			end
		end
	end

	// Range flags only ever set here; conversions never reach them
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_latched_underflow_flag <= fcm_pkg::FLAG_RESET;
			o_latched_overflow_flag  <= fcm_pkg::FLAG_RESET;
		end else if (p_mac) begin  // see RQ6
			o_latched_underflow_flag <= o_latched_underflow_flag
				| mul_res[33] | add_res[33];  // see RQ10 RQ16
			o_latched_overflow_flag  <= o_latched_overflow_flag
				| mul_res[32] | add_res[32];  // see RQ10 RQ16
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_float_negative_flag   <= fcm_pkg::FLAG_RESET;
			o_float_zero_flag       <= fcm_pkg::FLAG_RESET;
			o_integer_negative_flag <= fcm_pkg::FLAG_RESET;
			o_integer_zero_flag     <= fcm_pkg::FLAG_RESET;
		end else if (is_load) begin
			o_float_negative_flag   <= load_word[31] && (load_word[30:23] != 8'h00);  // see RQ17
			o_float_zero_flag       <= load_word[30:23] == 8'h00;  // see RQ17
			o_integer_negative_flag <= load_word[31];  // see RQ17
			o_integer_zero_flag     <= load_word == 32'h0000_0000;  // see RQ17
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_test_result_flag <= fcm_pkg::FLAG_RESET;
			o_rd_data          <= fcm_pkg::REG_RESET;
		end else begin
			o_test_result_flag <= o_test_result_flag;
			o_rd_data          <= regs[i_rd_sel];
		end
	end
endmodule : fcm_device
`default_nettype wire

//--- dv/fcm_props.sv
// Concurrent checks on the issue link and the status flags of the float datapath
`timescale 1ns/1ns
`default_nettype none
module fcm_props (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic        issue_valid,
	input wire logic [15:0] issue_lsw,
	input wire logic [15:0] issue_msw,
	input wire logic [31:0] issue_mem,
	input wire logic        o_integer_zero_flag,
	input wire logic        o_integer_negative_flag,
	input wire logic        o_float_zero_flag,
	input wire logic        o_float_negative_flag,
	input wire logic        o_latched_underflow_flag,
	input wire logic        o_latched_overflow_flag
);
	function automatic logic [7:0] one_hot(input logic [2:0] r);
		return 8'h01 << r;
	endfunction : one_hot

	wire       is_cvr = issue_lsw == 16'he689 && issue_msw[15:6] == 10'h000;
	wire       is_cvm = issue_lsw == 16'he288 && issue_msw[15:11] == 5'h00;
	wire       is_par = issue_lsw[15:2] == 14'h39d0;
	wire       is_mld = issue_lsw[15:4] == 12'he33;
	wire       mac    = issue_valid && (is_par || is_mld);
	wire [7:0] c_a    = one_hot(issue_msw[2:0]);
	wire [7:0] c_b    = one_hot(issue_msw[5:3]);
	wire [7:0] m_a    = one_hot(issue_msw[10:8]);
	wire [7:0] p_d    = one_hot(issue_msw[11:9]);
	wire [7:0] p_ef   = one_hot(issue_msw[14:12]) | one_hot({issue_lsw[1:0], issue_msw[15]});
	wire [7:0] l_d    = one_hot(issue_msw[13:11]);
	wire [7:0] l_ef   = one_hot({issue_lsw[0], issue_msw[15:14]}) | one_hot(issue_lsw[3:1]);
	// Registers still in flight after this instruction, and registers it uses
	wire [7:0] pend   = is_cvr ? c_a : is_cvm ? m_a : is_par ? (8'h08 | p_d) :
		is_mld ? (8'h08 | l_d) : 8'h00;
	wire [7:0] touch  = is_cvr ? (c_a | c_b) : is_cvm ? m_a : is_par ? (8'h0c | p_d | p_ef) :
		is_mld ? (8'h0c | l_d | l_ef | m_a) : 8'h00;
	wire       sgn    = issue_mem[31];
	wire       exz    = issue_mem[30:23] == 8'h00;
	wire       wz     = issue_mem == 32'h0000_0000;
	wire [5:0] flv    = {o_integer_zero_flag, o_integer_negative_flag, o_float_zero_flag,
		o_float_negative_flag, o_latched_underflow_flag, o_latched_overflow_flag};
	logic [7:0] pend_q;
	wire        clash = issue_valid && (touch & pend_q) != 8'h00;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_q <= 8'h00;
		end else begin
			pend_q <= issue_valid ? pend : 8'h00;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_cvt_slot_free: assert property (issue_valid && (is_cvr || is_cvm) |=> !clash)
		else $error("conversion delay slot uses its destination");
	a_par_slot_free: assert property (issue_valid && is_par |=> !clash)
		else $error("parallel add delay slot uses a destination");
	a_mld_slot_free: assert property (issue_valid && is_mld |=> !clash)
		else $error("load form delay slot uses a destination");
	a_par_dest_legal: assert property (issue_valid && is_par |-> issue_msw[11:9] != 3'h3)
		else $error("product destination three reached the device");
	a_load_dest_legal: assert property (issue_valid && is_mld |->
		issue_msw[10:8] != 3'h3 && issue_msw[10:8] != issue_msw[13:11])
		else $error("load destination clash reached the device");
	a_load_flags: assert property (issue_valid && is_mld |=>
		o_integer_negative_flag == $past(sgn) && o_integer_zero_flag == $past(wz) &&
		o_float_zero_flag == $past(exz) && o_float_negative_flag == ($past(sgn) && !$past(exz)))
		else $error("load flags do not follow the loaded word");
	a_cvt_flags_keep: assert property (issue_valid && (is_cvr || is_cvm) ##1
		!(issue_valid && is_mld) |=> $stable(flv))
		else $error("conversion changed a status flag");
	a_range_sticky: assert property (!$fell(o_latched_underflow_flag) &&
		!$fell(o_latched_overflow_flag))
		else $error("latched range flag cleared");
	a_range_cause: assert property ($rose(o_latched_underflow_flag) ||
		$rose(o_latched_overflow_flag) |-> $past(mac, 2))
		else $error("range flag rose without a multiply two cycles earlier");

	c_par_issue: cover property (issue_valid && is_par);
	c_mld_issue: cover property (issue_valid && is_mld);
	c_cvt_stall: cover property (issue_valid && is_cvr ##1 !issue_valid ##1 issue_valid);
endmodule : fcm_props
`default_nettype wire

//--- dv/fp_convert_mac_datapath_tb.sv
// Self-checking bench for the host and device ends of the float datapath
`timescale 1ns/1ns
`default_nettype none
module fp_convert_mac_datapath_tb;
	typedef struct {
		logic [31:0] op;
		logic [31:0] mem;
		logic        rz;
		logic [2:0]  sel;
		logic [31:0] exp;
	} fcm_row_t;

	logic        i_clk;
	logic        i_rst_b;
	logic        i_valid;
	logic [15:0] i_lsw;
	logic [15:0] i_msw;
	logic [31:0] i_mem;
	logic        i_round_zero;
	logic [2:0]  i_rd_sel;
	logic        o_ready;
	logic        o_illegal;
	logic [31:0] o_rd_data;
	logic [6:0]  flags;
	int          errors = 0;
	int          checks = 0;
	fcm_row_t    rows[14];

	fcm_if link ();
	fcm_host fcm_host_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link), .i_valid(i_valid),
		.i_lsw(i_lsw), .i_msw(i_msw), .i_mem(i_mem), .i_round_zero(i_round_zero),
		.o_ready(o_ready), .o_illegal(o_illegal));
	fcm_device fcm_device_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
		.i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data), .o_test_result_flag(flags[6]),
		.o_integer_zero_flag(flags[5]), .o_integer_negative_flag(flags[4]),
		.o_float_zero_flag(flags[3]), .o_float_negative_flag(flags[2]),
		.o_latched_underflow_flag(flags[1]), .o_latched_overflow_flag(flags[0]));
	fcm_props fcm_props_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .issue_valid(link.issue_valid),
		.issue_lsw(link.issue_lsw), .issue_msw(link.issue_msw), .issue_mem(link.issue_mem),
		.o_integer_zero_flag(flags[5]), .o_integer_negative_flag(flags[4]),
		.o_float_zero_flag(flags[3]), .o_float_negative_flag(flags[2]),
		.o_latched_underflow_flag(flags[1]), .o_latched_overflow_flag(flags[0]));

	function automatic logic [31:0] op_cvr(input logic [2:0] a, input logic [2:0] b);
		return {16'he689, 10'h000, b, a};
	endfunction : op_cvr
	function automatic logic [31:0] op_cvm(input logic [2:0] a);
		return {16'he288, 5'h00, a, 8'h00};
	endfunction : op_cvm
	function automatic logic [31:0] op_par(input logic [2:0] d, e, f);
		return {14'h39d0, f, e, d, 9'h000};
	endfunction : op_par
	function automatic logic [31:0] op_ld(input logic [2:0] a, d, e, f);
		return {12'he33, f, e, d, a, 8'h00};
	endfunction : op_ld

	task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check32

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// Holds the offer for up to 8 cycles until the host takes it; leaves i_valid high for back-to-back use
	task automatic issue(input logic [31:0] op, input logic [31:0] mem, input logic rz,
			output int stall);
		logic rdy;
		i_valid = 1'b1;
		i_lsw = op[31:16];
		i_msw = op[15:0];
		i_mem = mem;
		i_round_zero = rz;
		stall = 0;
		repeat (8) begin
			#1;
			rdy = o_ready;
			@(posedge i_clk);
			#1;
			if (rdy === 1'b1) break;
			stall++;
		end
	endtask : issue

	task automatic idle(input int n);
		i_valid = 1'b0;
		repeat (n) @(posedge i_clk);
		#1;
	endtask : idle

	task automatic timed(input logic [31:0] op, input logic [31:0] mem, input int lat,
			input logic fl, input logic [31:0] old, input logic [31:0] nxt);
		int s;
		issue(op, mem, 1'b0, s);
		idle(lat - 1);
		check32(fl ? {25'h0, flags} : o_rd_data, old, "value before latency");
		idle(1);
		check32(fl ? {25'h0, flags} : o_rd_data, nxt, "value after latency");
	endtask : timed

	task automatic pair(input logic [31:0] first, input logic [31:0] second, input int want);
		int s;
		issue(first, 32'h0, 1'b0, s);
		issue(second, 32'h0, 1'b0, s);
		idle(3);
		check32(s, want, "delay slot stall count");
	endtask : pair

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	initial begin
		repeat (2000) @(posedge i_clk);
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		int s;
		logic [31:0] bad[3];
		i_rst_b = 1'b0;
		i_valid = 1'b0;
		i_lsw = 16'h0000;
		i_msw = 16'h0000;
		i_mem = 32'h0000_0000;
		i_round_zero = 1'b0;
		i_rd_sel = 3'h0;
		rows = '{'{op_cvm(3'h1), 32'h11111111, 1'b1, 3'h1, 32'h4d888888},
			'{op_cvm(3'h1), 32'h11111111, 1'b0, 3'h1, 32'h4d888889},
			'{op_cvm(3'h4), 32'hffffffff, 1'b0, 3'h4, 32'hbf800000},
			'{op_cvm(3'h5), 32'h80000000, 1'b0, 3'h5, 32'hcf000000},
			'{op_ld(3'h0, 3'h7, 3'h7, 3'h7), 32'h00000005, 1'b0, 3'h0, 32'h00000005},
			'{op_cvr(3'h6, 3'h0), 32'h0, 1'b0, 3'h6, 32'h40a00000},
			'{op_ld(3'h0, 3'h7, 3'h7, 3'h7), 32'hfffffffc, 1'b0, 3'h0, 32'hfffffffc},
			'{op_cvr(3'h0, 3'h0), 32'h0, 1'b0, 3'h0, 32'hc0800000},
			'{op_ld(3'h2, 3'h7, 3'h7, 3'h7), 32'h40000000, 1'b0, 3'h2, 32'h40000000},
			'{op_par(3'h1, 3'h2, 3'h6), 32'h0, 1'b0, 3'h1, 32'h41200000},
			'{32'h0, 32'h0, 1'b0, 3'h3, 32'h40000000},
			'{op_ld(3'h4, 3'h5, 3'h6, 3'h6), 32'h3f800000, 1'b0, 3'h5, 32'h41c80000},
			'{32'h0, 32'h0, 1'b0, 3'h3, 32'h40800000},
			'{32'h0, 32'h0, 1'b0, 3'h4, 32'h3f800000}};
		bad = '{op_par(3'h3, 3'h0, 3'h0), op_ld(3'h3, 3'h5, 3'h0, 3'h0),
			op_ld(3'h4, 3'h4, 3'h0, 3'h0)};
		repeat (4) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		check32({25'h0, flags}, 32'h0, "flags after reset");
		foreach (rows[k]) begin
			i_rd_sel = rows[k].sel;
			issue(rows[k].op, rows[k].mem, rows[k].rz, s);
			idle(4);
			check32(o_rd_data, rows[k].exp, "table result");
		end
		$display("table test done");
		i_rd_sel = 3'h1;
		timed(op_cvm(3'h1), 32'h7, 3, 1'b0, 32'h41200000, 32'h40e00000);
		i_rd_sel = 3'h6;
		timed(op_ld(3'h6, 3'h7, 3'h7, 3'h7), 32'h80000000, 2, 1'b0,
			32'h40a00000, 32'h80000000);
		check32({28'h0, flags[5:2]}, 32'h6, "load flags");
		issue(op_ld(3'h0, 3'h7, 3'h7, 3'h7), 32'h7f000000, 1'b0, s);
		idle(3);
		timed(op_par(3'h1, 3'h0, 3'h0), 32'h0, 2, 1'b1, 32'h0, 32'h1);
		issue(op_ld(3'h0, 3'h7, 3'h7, 3'h7), 32'h00800000, 1'b0, s);
		idle(3);
		timed(op_par(3'h1, 3'h0, 3'h0), 32'h0, 2, 1'b1, 32'h1, 32'h3);
		$display("latency and range test done");
		pair(op_cvr(3'h5, 3'h6), op_cvr(3'h4, 3'h5), 1);
		pair(op_cvr(3'h5, 3'h6), op_cvr(3'h4, 3'h6), 0);
		pair(op_par(3'h1, 3'h0, 3'h0), op_cvr(3'h4, 3'h3), 1);
		pair(op_ld(3'h6, 3'h7, 3'h7, 3'h7), op_cvr(3'h4, 3'h7), 1);
		$display("delay slot test done");
		foreach (bad[k]) begin
			issue(bad[k], 32'hdeadbeef, 1'b0, s);
			check32({30'h0, o_illegal, link.issue_valid}, 32'h2, "dropped form");
			idle(1);
			check32({31'h0, o_illegal}, 32'h0, "drop pulse ends");
		end
		$display("forbidden form test done");
		i_rst_b = 1'b0;
		#1;
		check32(o_rd_data, 32'h0, "data in reset");
		check32({25'h0, flags}, 32'h0, "flags in reset");
		idle(2);
		i_rst_b = 1'b1;
		idle(2);
		check32({25'h0, flags}, 32'h0, "flags after second reset");
		$display("reset test done");
		report_and_stop();
	end
endmodule : fp_convert_mac_datapath_tb
`default_nettype wire
